// >>> hw/spk_route_ctrl.v
// Speaker output routing control register and its decoded controls.
// Assumes an Avalon-MM master on CLK and analog drivers that take
// the level outputs below as their routing, mute and power controls.
//
// Register access over Avalon-MM is this design's own decision.
`timescale 1ns/1ns
`default_nettype none
`include "spk_route_defs.vh"

// Behaviour
// - D15 selects single-ended or differential pairing
// - Differential powers pair down unless both up
// - Speaker A converter code: none/left/right/average
// - D12-D9 connect four sources to speaker A
// - Speaker B converter code, single-ended only
// - D6-D3 connect sources to B, single-ended only
// - D2 mutes speaker A, resets muted
// - D1 mutes speaker B, single-ended, resets muted
// - D0 write-only protection disable, resets enabled
module spk_route_ctrl (
  input wire CLK,
  input wire RESETN,
  input wire CE,
  input wire [7:0] ADDRESS,
  input wire READ,
  input wire WRITE,
  input wire [31:0] WRITEDATA,
  input wire [3:0] BYTEENABLE,
  output reg [31:0] READDATA,
  output wire WAITREQUEST,
  output reg [1:0] RESPONSE,
  input wire SPEAKER_A_POWER_REQ,
  input wire SPEAKER_B_POWER_REQ,
  input wire EARPIECE_NEG_POWER_REQ,
  output reg DIFFERENTIAL_OUTPUT_SELECT,
  output reg SPEAKER_A_DAC_LEFT,
  output reg SPEAKER_A_DAC_RIGHT,
  output reg SPEAKER_A_DAC_HALVE,
  output reg SIDETONE_TO_SPEAKER_A,
  output reg BUZZER_TO_SPEAKER_A,
  output reg KEYCLICK_TO_SPEAKER_A,
  output reg PHONE_INPUT_TO_SPEAKER_A,
  output reg SPEAKER_B_DAC_LEFT,
  output reg SPEAKER_B_DAC_RIGHT,
  output reg SPEAKER_B_DAC_HALVE,
  output reg SIDETONE_TO_SPEAKER_B,
  output reg BUZZER_TO_SPEAKER_B,
  output reg KEYCLICK_TO_SPEAKER_B,
  output reg PHONE_INPUT_TO_SPEAKER_B,
  output reg SPEAKER_A_MUTE,
  output reg SPEAKER_B_MUTE,
  output reg HEADPHONE_SHORT_PROTECT_DISABLE,
  output reg SPEAKER_A_POWER,
  output reg SPEAKER_B_POWER,
  output reg EARPIECE_NEG_POWER
);

  // ----------------------------------------------------------------
  // Local state
  // ----------------------------------------------------------------
  localparam ST_IDLE = 2'b01;
  localparam ST_DONE = 2'b10;

  reg [1:0] state;
  reg [1:0] next_state;
  reg [15:0] route_ctrl;
  reg [15:0] next_route_ctrl;
  reg [2:0] req_meta;
  reg [2:0] req_sync;
  wire req;
  wire hit_ctrl;
  wire hit_stat;
  wire a_left;
  wire a_right;
  wire a_halve;
  wire b_left;
  wire b_right;
  wire b_halve;
  wire diff;
  wire single;

  assign req = READ | WRITE;
  assign hit_ctrl = (ADDRESS == `ROUTE_CTRL_OFFSET);
  assign hit_stat = (ADDRESS == `POWER_STAT_OFFSET);
  assign diff = route_ctrl[`F_DIFF];
  assign single = ~diff;

  // Byte-lane merge of a write into a 16-bit register
  function [15:0] merge16;
    input [15:0] old;
    input [31:0] data;
    input [3:0] be;
    begin
      merge16 = old;
      if (be[0])
        merge16[7:0] = data[7:0];
      if (be[1])
        merge16[15:8] = data[15:8];
    end
  endfunction

  // ----------------------------------------------------------------
  // Bus slave: one wait cycle, answer on the second cycle
  // ----------------------------------------------------------------
  // Waitrequest is high on the first cycle of every request; it also
  // stays high while the clock enable freezes the completing cycle,
  // so no access can complete while the register cannot take it
  assign WAITREQUEST = req & ~(state[1] & CE);

  // Handshake state
  always @* begin
    next_state = state;
    case (state)
      ST_IDLE: begin
        if (req)
          next_state = ST_DONE;
      end
      ST_DONE: next_state = ST_IDLE;
      default: next_state = ST_IDLE;
    endcase
  end

  // Register update only on the completing edge
  always @* begin
    next_route_ctrl = route_ctrl;
    if (WRITE && state[1] && hit_ctrl)
      next_route_ctrl = merge16(route_ctrl, WRITEDATA, BYTEENABLE);
  end

  always @(posedge CLK) begin
    if (!RESETN) begin
      state <= ST_IDLE;
      route_ctrl <= `ROUTE_CTRL_RESET;
    end else if (CE) begin
      state <= next_state;
      route_ctrl <= next_route_ctrl;
    end
  end

  // Read data and response, registered while waitrequest is high
  always @(posedge CLK) begin
    if (!RESETN) begin
      READDATA <= 32'h00000000;
      RESPONSE <= `RESP_OKAY;
    end else if (CE) begin
      if (req && state[0]) begin
        READDATA <= 32'h00000000;
        RESPONSE <= `RESP_OKAY;
        if (hit_ctrl)
          READDATA[15:0] <= route_ctrl & `ROUTE_READ_MASK;
        else if (hit_stat)
          READDATA[2:0] <= {EARPIECE_NEG_POWER, SPEAKER_B_POWER,
                            SPEAKER_A_POWER};
        else
          RESPONSE <= `RESP_SLVERR; // Unmapped: slave error
      end
    end
  end

  // ----------------------------------------------------------------
  // Power requests cross from the analog control domain
  // ----------------------------------------------------------------
  // Two flops before any logic reads the requests
  always @(posedge CLK) begin
    if (!RESETN) begin
      req_meta <= 3'h0;
      req_sync <= 3'h0;
    end else if (CE) begin
      req_meta <= {EARPIECE_NEG_POWER_REQ, SPEAKER_B_POWER_REQ,
                   SPEAKER_A_POWER_REQ};
      req_sync <= req_meta;
    end
  end

  // ----------------------------------------------------------------
  // Decoded routing
  // ----------------------------------------------------------------
  spk_conv_decode u_dec_a (
    .CODE(route_ctrl[`F_CONV_A_HI:`F_CONV_A_LO]),
    .ALLOW(1'b1),
    .LEFT_EN(a_left),
    .RIGHT_EN(a_right),
    .HALVE(a_halve)
  );

  spk_conv_decode u_dec_b (
    .CODE(route_ctrl[`F_CONV_B_HI:`F_CONV_B_LO]),
    .ALLOW(single),
    .LEFT_EN(b_left),
    .RIGHT_EN(b_right),
    .HALVE(b_halve)
  );

  // Outputs registered so the drivers never see decode glitches
  always @(posedge CLK) begin
    if (!RESETN) begin
      DIFFERENTIAL_OUTPUT_SELECT <= 1'b0;
      SPEAKER_A_DAC_LEFT <= 1'b0;
      SPEAKER_A_DAC_RIGHT <= 1'b0;
      SPEAKER_A_DAC_HALVE <= 1'b0;
      SIDETONE_TO_SPEAKER_A <= 1'b0;
      BUZZER_TO_SPEAKER_A <= 1'b0;
      KEYCLICK_TO_SPEAKER_A <= 1'b0;
      PHONE_INPUT_TO_SPEAKER_A <= 1'b0;
      SPEAKER_B_DAC_LEFT <= 1'b0;
      SPEAKER_B_DAC_RIGHT <= 1'b0;
      SPEAKER_B_DAC_HALVE <= 1'b0;
      SIDETONE_TO_SPEAKER_B <= 1'b0;
      BUZZER_TO_SPEAKER_B <= 1'b0;
      KEYCLICK_TO_SPEAKER_B <= 1'b0;
      PHONE_INPUT_TO_SPEAKER_B <= 1'b0;
      SPEAKER_A_MUTE <= 1'b1;
      SPEAKER_B_MUTE <= 1'b1;
      HEADPHONE_SHORT_PROTECT_DISABLE <= 1'b0;
      SPEAKER_A_POWER <= 1'b0;
      SPEAKER_B_POWER <= 1'b0;
      EARPIECE_NEG_POWER <= 1'b0;
    end else if (CE) begin
      DIFFERENTIAL_OUTPUT_SELECT <= diff;
      SPEAKER_A_DAC_LEFT <= a_left;
      SPEAKER_A_DAC_RIGHT <= a_right;
      SPEAKER_A_DAC_HALVE <= a_halve;
      {SIDETONE_TO_SPEAKER_A, BUZZER_TO_SPEAKER_A, KEYCLICK_TO_SPEAKER_A,
       PHONE_INPUT_TO_SPEAKER_A} <=
        route_ctrl[`F_SRC_A_HI:`F_SRC_A_LO];
      SPEAKER_B_DAC_LEFT <= b_left;
      SPEAKER_B_DAC_RIGHT <= b_right;
      SPEAKER_B_DAC_HALVE <= b_halve;
      {SIDETONE_TO_SPEAKER_B, BUZZER_TO_SPEAKER_B, KEYCLICK_TO_SPEAKER_B,
       PHONE_INPUT_TO_SPEAKER_B} <=
        route_ctrl[`F_SRC_B_HI:`F_SRC_B_LO] & {4{single}};
      SPEAKER_A_MUTE <= route_ctrl[`F_MUTE_A];
      // Speaker B is unused in differential mode, so hold it muted
      SPEAKER_B_MUTE <= route_ctrl[`F_MUTE_B] | diff;
      HEADPHONE_SHORT_PROTECT_DISABLE <= route_ctrl[`F_SCP_DIS];
      if (diff) begin
        // Pair only runs when both halves are requested up
        SPEAKER_A_POWER <= req_sync[0] & req_sync[2];
        EARPIECE_NEG_POWER <= req_sync[0] & req_sync[2];
        SPEAKER_B_POWER <= req_sync[1];
      end else begin
        SPEAKER_A_POWER <= req_sync[0];
        EARPIECE_NEG_POWER <= req_sync[2];
        SPEAKER_B_POWER <= req_sync[1];
      end
    end
  end

endmodule
`default_nettype wire

// >>> hw/spk_route_defs.vh
// Constants for the speaker output routing control block.
// Assumes inclusion by bare name from the design files only.
`ifndef SPK_ROUTE_DEFS_VH
`define SPK_ROUTE_DEFS_VH

// ----------------------------------------------------------------
// Register map (byte addresses on the word bus)
// ----------------------------------------------------------------
`define ROUTE_CTRL_OFFSET 8'h20
`define POWER_STAT_OFFSET 8'h24
`define ADDR_WIDTH 8
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

// ----------------------------------------------------------------
// Routing control field positions
// ----------------------------------------------------------------
`define F_DIFF 15
`define F_CONV_A_HI 14
`define F_CONV_A_LO 13
`define F_SRC_A_HI 12
`define F_SRC_A_LO 9
`define F_CONV_B_HI 8
`define F_CONV_B_LO 7
`define F_SRC_B_HI 6
`define F_SRC_B_LO 3
`define F_MUTE_A 2
`define F_MUTE_B 1
`define F_SCP_DIS 0

// Reset image: both mutes set, everything else clear
`define ROUTE_CTRL_RESET 16'h0006
// Bit 0 is write-only and reads back as zero
`define ROUTE_READ_MASK 16'hfffe

// ----------------------------------------------------------------
// Converter routing codes
// ----------------------------------------------------------------
`define CONV_NONE 2'h0
`define CONV_LEFT 2'h1
`define CONV_RIGHT 2'h2
`define CONV_AVG 2'h3

`endif

// >>> hw/spk_conv_decode.v
// Decodes one two-bit converter routing code into channel enables.
// Assumes a purely combinational use from the routing control block.
`timescale 1ns/1ns
`default_nettype none
`include "spk_route_defs.vh"

module spk_conv_decode (
  input wire [1:0] CODE,
  input wire ALLOW,
  output reg LEFT_EN,
  output reg RIGHT_EN,
  output reg HALVE
);

  // Average feeds both channels at half weight
  always @* begin
    LEFT_EN = 1'b0;
    RIGHT_EN = 1'b0;
    HALVE = 1'b0;
    if (ALLOW) begin
      case (CODE)
        `CONV_LEFT: LEFT_EN = 1'b1;
        `CONV_RIGHT: RIGHT_EN = 1'b1;
        `CONV_AVG: begin
          LEFT_EN = 1'b1;
          RIGHT_EN = 1'b1;
          HALVE = 1'b1;
        end
        default: LEFT_EN = 1'b0;
      endcase
    end
  end

endmodule
`default_nettype wire

// >>> verif/spk_route_ctrl_properties.sv
// Checker for the speaker routing control block.
// Assumes it is bound onto spk_route_ctrl and sees only its ports.
`timescale 1ns/1ns
`default_nettype none
module spk_route_ctrl_checker (
  input wire logic CLK,
  input wire logic RESETN,
  input wire logic CE,
  input wire logic [7:0] ADDRESS,
  input wire logic READ,
  input wire logic WRITE,
  input wire logic [31:0] WRITEDATA,
  input wire logic [3:0] BYTEENABLE,
  input wire logic [31:0] READDATA,
  input wire logic WAITREQUEST,
  input wire logic [1:0] RESPONSE,
  input wire logic DIFFERENTIAL_OUTPUT_SELECT,
  input wire logic SPEAKER_A_DAC_LEFT,
  input wire logic SPEAKER_A_DAC_RIGHT,
  input wire logic SPEAKER_A_DAC_HALVE,
  input wire logic SPEAKER_A_MUTE,
  input wire logic SPEAKER_B_MUTE,
  input wire logic HEADPHONE_SHORT_PROTECT_DISABLE,
  input wire logic SPEAKER_A_POWER,
  input wire logic EARPIECE_NEG_POWER
);
  // Completed access to the routing register
  wire wr = WRITE && !WAITREQUEST && CE && ADDRESS == 8'h20;
  wire rd = READ && !WAITREQUEST && CE && ADDRESS == 8'h20;
  wire dif = DIFFERENTIAL_OUTPUT_SELECT;
  default clocking @(posedge CLK); endclocking
  default disable iff (!RESETN);
  // --------
  // Properties
  // --------
  a_wait_one:
    assert property ((READ || WRITE) && WAITREQUEST && CE |=>
    !WAITREQUEST || !CE) else $error("wait too long");
  a_diff_set:
    assert property (wr && BYTEENABLE[1] ##1 CE [*2] |->
    dif == $past(WRITEDATA[15], 2)) else $error("diff select");
  a_mute_a_set:
    assert property (wr && BYTEENABLE[0] ##1 CE [*2] |->
    SPEAKER_A_MUTE == $past(WRITEDATA[2], 2)) else $error("mute a");
  a_protect_set:
    assert property (wr && BYTEENABLE[0] ##1 CE [*2] |->
    HEADPHONE_SHORT_PROTECT_DISABLE == $past(WRITEDATA[0], 2))
    else $error("protect");
  a_mute_b_diff:
    assert property (dif |-> SPEAKER_B_MUTE) else $error("mute b");
  a_avg_both:
    assert property (SPEAKER_A_DAC_HALVE |-> SPEAKER_A_DAC_LEFT &&
    SPEAKER_A_DAC_RIGHT) else $error("average");
  a_pair_power:
    assert property (dif && $past(dif) |->
    SPEAKER_A_POWER == EARPIECE_NEG_POWER) else $error("pair power");
  a_read_clean:
    assert property (rd |-> READDATA[0] == 1'b0 &&
    READDATA[31:16] == 16'h0 && RESPONSE == 2'h0) else $error("read");
  a_mute_hold:
    assert property (!$past(wr) && !$past(wr, 2) |->
    $stable(SPEAKER_A_MUTE)) else $error("mute a moved");
endmodule
bind spk_route_ctrl spk_route_ctrl_checker chk_u (.*);
`default_nettype wire

// >>> verif/test_speaker_output_routing_control.sv
// Self-checking bench for the speaker routing control block.
// Assumes spk_route_ctrl and its checker are compiled alongside.
`timescale 1ns/1ns
`default_nettype none
module test_speaker_output_routing_control;
  logic CLK = 0, RESETN = 0, CE = 1, READ = 0, WRITE = 0;
  logic [7:0] ADDRESS = 8'h0;
  logic [31:0] WRITEDATA = 32'h0, rd, d;
  logic [3:0] BYTEENABLE = 4'h0, b;
  logic [2:0] rq = 3'h0, p;
  logic [1:0] rs;
  logic [15:0] m;
  logic [17:0] e;
  wire [31:0] READDATA;
  wire [1:0] RESPONSE;
  wire [17:0] ov;
  wire [2:0] pw;
  wire WAITREQUEST;
  int err_count = 0, tests_run = 0, i;
  always #5 CLK = ~CLK;
  spk_route_ctrl dut_u (
    .CLK(CLK),
    .RESETN(RESETN),
    .CE(CE),
    .ADDRESS(ADDRESS),
    .READ(READ),
    .WRITE(WRITE),
    .WRITEDATA(WRITEDATA),
    .BYTEENABLE(BYTEENABLE),
    .READDATA(READDATA),
    .WAITREQUEST(WAITREQUEST),
    .RESPONSE(RESPONSE),
    .SPEAKER_A_POWER_REQ(rq[0]),
    .SPEAKER_B_POWER_REQ(rq[1]),
    .EARPIECE_NEG_POWER_REQ(rq[2]),
    .DIFFERENTIAL_OUTPUT_SELECT(ov[17]),
    .SPEAKER_A_DAC_LEFT(ov[16]),
    .SPEAKER_A_DAC_RIGHT(ov[15]),
    .SPEAKER_A_DAC_HALVE(ov[14]),
    .SIDETONE_TO_SPEAKER_A(ov[13]),
    .BUZZER_TO_SPEAKER_A(ov[12]),
    .KEYCLICK_TO_SPEAKER_A(ov[11]),
    .PHONE_INPUT_TO_SPEAKER_A(ov[10]),
    .SPEAKER_B_DAC_LEFT(ov[9]),
    .SPEAKER_B_DAC_RIGHT(ov[8]),
    .SPEAKER_B_DAC_HALVE(ov[7]),
    .SIDETONE_TO_SPEAKER_B(ov[6]),
    .BUZZER_TO_SPEAKER_B(ov[5]),
    .KEYCLICK_TO_SPEAKER_B(ov[4]),
    .PHONE_INPUT_TO_SPEAKER_B(ov[3]),
    .SPEAKER_A_MUTE(ov[2]),
    .SPEAKER_B_MUTE(ov[1]),
    .HEADPHONE_SHORT_PROTECT_DISABLE(ov[0]),
    .SPEAKER_A_POWER(pw[0]),
    .SPEAKER_B_POWER(pw[1]),
    .EARPIECE_NEG_POWER(pw[2])
  );
  // --------
  // Tasks
  // --------
  task complete_run;
    $display("checks %0d errors %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task chk(input string s, input logic [31:0] seen, input logic [31:0] x);
    tests_run++;
    if (seen !== x) begin
      err_count++;
      $display("[FAIL] %s exp %h seen %h", s, x, seen);
    end
  endtask
  // One Avalon access; held until waitrequest is sampled low
  task bus(input logic r, input logic [7:0] a, input logic [31:0] v,
    input logic [3:0] be);
    int n;
    READ <= r;
    WRITE <= !r;
    ADDRESS <= a;
    WRITEDATA <= v;
    BYTEENABLE <= be;
    n = 0;
    @(posedge CLK);
    while (WAITREQUEST !== 1'b0) begin
      @(posedge CLK);
      n++;
      if (n > 20) begin
        err_count++;
        complete_run;
      end
    end
    rd = READDATA;
    rs = RESPONSE;
    READ <= 1'b0;
    WRITE <= 1'b0;
    @(posedge CLK);
  endtask
  // Expected outputs; B side forced off and muted when paired
  task outs;
    e = {m[15], m[13], m[14], &m[14:13], m[12:9], m[15] ? 7'h0 :
      {m[7], m[8], &m[8:7], m[6:3]}, m[2], m[15] | m[1], m[0]};
    chk("outputs", ov, e);
  endtask
  // Expected power: pair needs both requests when differential
  task pwr;
    p = m[15] ? {rq[2] & rq[0], rq[1], rq[2] & rq[0]} : rq;
    chk("power", pw, p);
  endtask
  task rst;
    RESETN <= 1'b0;
    repeat (4) @(posedge CLK);
    RESETN <= 1'b1;
    m = 16'h0006;
    @(posedge CLK);
    outs;
  endtask
  // --------
  // Main sequence
  // --------
  initial begin
    i = $urandom(32'he1883d81);
    rst;
    bus(1'b1, 8'h20, 32'h0, 4'h3);
    chk("reset read", rd, 32'h6);
    // Every converter code in both modes, partial lanes at the end
    for (i = 0; i < 16; i++) begin
      d = $urandom;
      d[15:13] = i[2:0];
      d[8:7] = i[1:0];
      b = i < 12 ? 4'h3 : {2'h0, d[20:19]};
      rq <= {i[0], i[3], i[1]};
      bus(1'b0, 8'h20, d, b);
      if (b[0]) m[7:0] = d[7:0];
      if (b[1]) m[15:8] = d[15:8];
      repeat (2) @(posedge CLK);
      outs;
      p = m[15] ? {rq[2] & rq[0], rq[1], rq[2] & rq[0]} : rq;
      chk("power", pw, p);
      bus(1'b1, 8'h24, 32'h0, 4'h3);
      chk("status", rd, p);
      bus(1'b1, 8'h20, 32'h0, 4'h3);
      chk("readback", rd, m & 16'hfffe);
    end
    // Unmapped place: refused and register untouched
    bus(1'b0, 8'h40, 32'hffff, 4'h3);
    bus(1'b1, 8'h40, 32'h0, 4'h3);
    chk("unmapped", {rs, rd[29:0]}, 32'h80000000);
    outs;
    // Enable low in the completing cycle: the write has to wait
    d = $urandom;
    fork
      bus(1'b0, 8'h20, d, 4'h3);
      begin
        @(posedge CLK);
        CE <= 1'b0;
        repeat (3) @(posedge CLK);
        CE <= 1'b1;
      end
    join
    m = d[15:0];
    repeat (2) @(posedge CLK);
    outs;
    pwr;
    bus(1'b1, 8'h20, 32'h0, 4'h3);
    chk("stalled write", rd, m & 16'hfffe);
    // Frozen state ignores new power requests until enabled again
    CE <= 1'b0;
    rq <= ~rq;
    repeat (4) @(posedge CLK);
    chk("frozen power", pw, p);
    outs;
    CE <= 1'b1;
    repeat (4) @(posedge CLK);
    pwr;
    // Reset in mid-run brings back the register image
    rst;
    bus(1'b1, 8'h20, 32'h0, 4'h3);
    chk("second reset", rd, 32'h6);
    pwr;
    complete_run;
  end
endmodule
`default_nettype wire
